// ---- pkg/nco_consts.vh ----
`ifndef NCO_CONSTS_VH
`define NCO_CONSTS_VH
`define NCO_ADDR_W        12
`define NCO_OFF_CTRL      12'h000
`define NCO_OFF_CLKCTRL   12'h004
`define NCO_OFF_INCR      12'h008
`define NCO_BIT_EN        7
`define NCO_BIT_OE        6
`define NCO_BIT_OUT       5
`define NCO_BIT_POL       4
`define NCO_BIT_PFM       0
`define NCO_CTRL_RESET    8'h00
`define NCO_CLK_PWS_HI    7
`define NCO_CLK_PWS_LO    5
`define NCO_CLK_RESET     8'h00
`define NCO_INCR_RESET    20'h00001
`define NCO_PWS_W         3
`define NCO_DATA_W        32
`define NCO_CTRL_W        8
`define NCO_RSV_W         3
`define NCO_CLK_LOW_W     5
`define NCO_BIT_RESET     1'b0
`define NCO_PWS_RESET     3'h0
`define NCO_PW_CNT_W      8
`endif

// ---- logic/nco_core.v ----
`timescale 1ns/1ps
`default_nettype none
module nco_core #(
  parameter ACC_W = 20,
  parameter PW_W  = 8
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             run,
  input  wire             pfm,
  input  wire [2:0]       pws,
  input  wire [ACC_W-1:0] incr,
  output reg              raw_out
);
  reg  [ACC_W-1:0] acc;
  reg  [PW_W-1:0]  width_cnt;
  wire [ACC_W:0]   sum = {1'b0, acc} + {1'b0, incr};
  wire             ovf = sum[ACC_W];
  wire [PW_W-1:0]  width_len = {{(PW_W-1){1'b0}}, 1'b1} << pws;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc       <= {ACC_W{1'b0}};
      width_cnt <= {PW_W{1'b0}};
      raw_out   <= 1'b0;
    end else if (!run) begin
      acc       <= {ACC_W{1'b0}};
      width_cnt <= {PW_W{1'b0}};
      raw_out   <= 1'b0;
    end else begin
      acc <= sum[ACC_W-1:0];
      if (pfm) begin
        // Pulse of 2^pws cycles per overflow
        if (ovf) begin
          raw_out   <= 1'b1;
          width_cnt <= width_len - {{(PW_W-1){1'b0}}, 1'b1};
        end else if (width_cnt != {PW_W{1'b0}}) begin
          width_cnt <= width_cnt - {{(PW_W-1){1'b0}}, 1'b1};
        end else begin
          raw_out <= 1'b0;
        end
      end else begin
        // Fixed duty: toggle on overflow
        width_cnt <= {PW_W{1'b0}};
        if (ovf)
          raw_out <= ~raw_out;
      end
    end
  end
endmodule
`default_nettype wire

// ---- logic/nco_ctrl.v ----
// Overview of operation
// - Channel runs only while control bit 7 enable is one.
// - Bit 6 one drives oscillator output to pin; zero disables pin.
// - Bit 5 read-only, reports present output level.
// - Bit 4 one inverts output to active low.
// - Pulse width select only acts in pulse frequency mode.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "nco_consts.vh"
module nco_ctrl #(
  parameter ACC_W = 20
) (
  input  wire                     pclk,
  input  wire                     presetn,
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [`NCO_ADDR_W-1:0]   paddr,
  input  wire [31:0]              pwdata,
  output reg  [31:0]              prdata,
  output reg                      pready,
  output reg                      pslverr,
  output reg                      nco_pin_out,
  output reg                      nco_pin_oe
);
  localparam DATA_W = `NCO_DATA_W;
  localparam CTRL_W = `NCO_CTRL_W;
  localparam PWS_W  = `NCO_PWS_W;

  // Control register fields
  reg                 channel_enable;
  reg                 pin_output_enable;
  reg                 output_polarity;
  reg                 pulse_frequency_mode_select;
  // Clock control and increment fields
  reg  [PWS_W-1:0]    pulse_width_select;
  reg  [ACC_W-1:0]    incr;
  // Oscillator output before and after polarity
  wire                raw_out;
  wire                output_level;
  // Bus phase tracking
  wire                setup;
  wire                access_phase;
  reg                 access;
  // Address decode
  wire                hit;
  wire                sel_ctrl;
  wire                sel_clk;
  wire                sel_incr;
  // Write strobes
  wire                wr_ok;
  wire                wr_ctrl;
  wire                wr_clk;
  wire                wr_incr;
  // Read views
  wire [CTRL_W-1:0]   oscillator_channel_control;
  wire [CTRL_W-1:0]   clock_control_view;
  wire [DATA_W-1:0]   incr_view;
  reg  [DATA_W-1:0]   next_rdata;
  reg  [DATA_W-1:0]   next_prdata;
  reg                 next_pslverr;
  // Pin values one cycle ahead
  wire                next_pin_out;
  wire                next_pin_oe;

  assign output_level = raw_out ^ output_polarity;

  // Setup is the first bus cycle, access the one where ready answers
  assign setup        = psel & ~penable;
  assign access_phase = psel & penable & access;

  assign sel_ctrl = (paddr == `NCO_OFF_CTRL);
  assign sel_clk  = (paddr == `NCO_OFF_CLKCTRL);
  assign sel_incr = (paddr == `NCO_OFF_INCR);
  assign hit      = sel_ctrl | sel_clk | sel_incr;

  // Writes land at the edge that closes the access phase
  assign wr_ok   = access_phase & pready & pwrite & hit;
  assign wr_ctrl = wr_ok & sel_ctrl;
  assign wr_clk  = wr_ok & sel_clk;
  assign wr_incr = wr_ok & sel_incr;

  assign oscillator_channel_control = {channel_enable, pin_output_enable, output_level,
                                       output_polarity, {`NCO_RSV_W{1'b0}},
                                       pulse_frequency_mode_select};
  assign clock_control_view = {pulse_width_select, {`NCO_CLK_LOW_W{1'b0}}};
  assign incr_view          = {{(DATA_W-ACC_W){1'b0}}, incr};

  always @* begin
    next_rdata = {DATA_W{1'b0}};
    case (paddr)
      `NCO_OFF_CTRL: begin
        next_rdata = {{(DATA_W-CTRL_W){1'b0}}, oscillator_channel_control};
      end
      `NCO_OFF_CLKCTRL: begin
        next_rdata = {{(DATA_W-CTRL_W){1'b0}}, clock_control_view};
      end
      `NCO_OFF_INCR: begin
        next_rdata = incr_view;
      end
      default: begin
        next_rdata = {DATA_W{1'b0}};
      end
    endcase
  end

  // Read data only in a read access, zero otherwise
  always @* begin
    next_prdata  = {DATA_W{1'b0}};
    next_pslverr = 1'b0;
    if (setup) begin
      next_pslverr = ~hit;
      if (!pwrite) begin
        next_prdata = next_rdata;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access <= 1'b0;
    end else begin
      access <= setup;
    end
  end

  // No wait state: ready in the cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_pslverr;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= {DATA_W{1'b0}};
    end else begin
      prdata <= next_prdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_enable <= `NCO_BIT_RESET;
    end else if (wr_ctrl) begin
      channel_enable <= pwdata[`NCO_BIT_EN];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_output_enable <= `NCO_BIT_RESET;
    end else if (wr_ctrl) begin
      pin_output_enable <= pwdata[`NCO_BIT_OE];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_polarity <= `NCO_BIT_RESET;
    end else if (wr_ctrl) begin
      output_polarity <= pwdata[`NCO_BIT_POL];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_frequency_mode_select <= `NCO_BIT_RESET;
    end else if (wr_ctrl) begin
      pulse_frequency_mode_select <= pwdata[`NCO_BIT_PFM];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_width_select <= `NCO_PWS_RESET;
    end else if (wr_clk) begin
      pulse_width_select <= pwdata[`NCO_CLK_PWS_HI:`NCO_CLK_PWS_LO];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      incr <= `NCO_INCR_RESET;
    end else if (wr_incr) begin
      incr <= pwdata[ACC_W-1:0];
    end
  end

  nco_core #(
    .ACC_W (ACC_W),
    .PW_W  (`NCO_PW_CNT_W)
  ) u_core (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (channel_enable),
    .pfm     (pulse_frequency_mode_select),
    .pws     (pulse_width_select),
    .incr    (incr),
    .raw_out (raw_out)
  );

  // Pin stays low while its output is disabled
  assign next_pin_out = pin_output_enable & output_level;
  assign next_pin_oe  = pin_output_enable;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nco_pin_out <= 1'b0;
    end else begin
      nco_pin_out <= next_pin_out;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nco_pin_oe <= 1'b0;
    end else begin
      nco_pin_oe <= next_pin_oe;
    end
  end
endmodule
`default_nettype wire

// ---- verif/nco_ctrl_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module nco_ctrl_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        nco_pin_out,
  input wire logic        nco_pin_oe
);
  logic [7:0] ctl;
  wire        rd0 = pready && !pwrite && paddr == 12'h000;
  // Shadow of the control register
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) ctl <= 8'h00;
    else if (psel && penable && pready && pwrite && paddr == 12'h000) ctl <= pwdata[7:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready timing");
  chk_oe_delay: assert property (nco_pin_oe == $past(ctl[6]))
    else $error("pin enable");
  chk_pin_off: assert property (!$past(ctl[6]) |-> !nco_pin_out)
    else $error("pin not off");
  chk_idle_pol: assert property ($past(ctl[7:6]) == 2'b01 && !$past(ctl[7], 2)
    && !$past(ctl[7], 3) |-> nco_pin_out == $past(ctl[4])) else $error("idle level");
  chk_read_fields: assert property (rd0 |-> {prdata[31:6], prdata[4:0]}
    == {24'h0, ctl[7:6], ctl[4], 3'h0, ctl[0]}) else $error("read fields");
  chk_level_pin: assert property (rd0 && $past(ctl[6]) |-> nco_pin_out == prdata[5])
    else $error("level bit");
  chk_unmapped_err: assert property (pready && paddr == 12'h00c |-> pslverr && prdata == 0)
    else $error("unmapped");
  cover property (rd0 && prdata[5]);
  cover property (pslverr);
  cover property ($rose(nco_pin_out));
endmodule
bind nco_ctrl nco_ctrl_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .nco_pin_out(nco_pin_out), .nco_pin_oe(nco_pin_oe));
`default_nettype wire

// ---- verif/test_nco_control_register.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_nco_control_register;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, nco_pin_out, nco_pin_oe, err;
  int          num_errors = 0, checked = 0;
  nco_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nco_pin_out(nco_pin_out), .nco_pin_oe(nco_pin_oe));
  initial forever #5 pclk = ~pclk;
  task automatic summarize;
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) num_errors++;
    if (n == 20) summarize();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_bits;
    apb(0, 12'h000, 0);
    cmp(rd, 32'h0);
    apb(1, 12'h000, 32'hff);
    apb(0, 12'h000, 0);
    cmp(rd, 32'hf1);
    apb(0, 12'h00c, 0);
    cmp({rd[30:0], err}, 32'h1);
    apb(1, 12'h008, 32'h40000);
    apb(0, 12'h008, 0);
    cmp(rd, 32'h40000);
  endtask
  // Counts high pin cycles over 16 cycles with overflow every 4
  task automatic t_mode(input logic [7:0] c, input logic [7:0] k, input logic [31:0] exp);
    logic [31:0] h;
    apb(1, 12'h000, 0);
    apb(1, 12'h004, {24'h0, k});
    apb(1, 12'h000, {24'h0, c});
    h = 0;
    repeat (8) @(posedge pclk);
    repeat (16) begin
      @(posedge pclk);
      h = h + nco_pin_out;
    end
    cmp(h, exp);
    cmp({31'h0, nco_pin_oe}, {31'h0, c[6]});
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_bits();
    t_mode(8'hc0, 8'h00, 8);
    t_mode(8'hc0, 8'he0, 8);
    t_mode(8'hc1, 8'h00, 4);
    t_mode(8'hc1, 8'h20, 8);
    t_mode(8'hd1, 8'h00, 12);
    t_mode(8'h50, 8'h00, 16);
    t_mode(8'h80, 8'h00, 0);
    summarize();
  end
endmodule
`default_nettype wire
